// [gdp_pkg.sv]
// constants for the general digital io port block
package gdp_pkg;

  // ==========================================================
  // sizes
  localparam int GDP_PINS  = 8;
  localparam int GDP_PORTS = 4;
  localparam int GDP_AW    = 12;

  // ==========================================================
  // register map, byte addresses
  localparam logic [11:0] GDP_STRIDE      = 12'h020;
  localparam logic [11:0] GDP_OFS_OUT     = 12'h000;
  localparam logic [11:0] GDP_OFS_DIR     = 12'h004;
  localparam logic [11:0] GDP_OFS_IN      = 12'h008;
  localparam logic [11:0] GDP_OFS_OUT_SET = 12'h00c;
  localparam logic [11:0] GDP_OFS_OUT_CLR = 12'h010;
  localparam logic [11:0] GDP_OFS_DIR_SET = 12'h014;
  localparam logic [11:0] GDP_OFS_DIR_CLR = 12'h018;
  localparam logic [11:0] GDP_OFS_SPECIAL = 12'h100;

  // ==========================================================
  // fields
  localparam int GDP_PUD_BIT  = 2;
  localparam int GDP_PORT_LSB = 5;

  // ==========================================================
  // values after reset
  localparam logic [7:0] GDP_DIR_RST = 8'h00;
  localparam logic [7:0] GDP_OUT_RST = 8'h00;
  localparam logic       GDP_PUD_RST = 1'b0;
  localparam logic [7:0] GDP_SMP_RST = 8'h00;

endpackage

// [gdp_port.sv]
// general digital io ports with apb register access
//
// Summary of operation
// - each port has output-data, direction and input-sample locations
// - input-sample is read only; output-data and direction read/write
// - global pull-up disable turns off every pull-up of every port
// - direction bit one makes pin output, zero makes it input
// - input pin with data one gets pull-up; else pull-up off
// - reset forces every pin to high impedance, clock or not
// - output pin drives pad high for data one, low for zero
// - pin state follows direction, data and pull-up disable table
// - input-sample shows synchronized pad level whatever the direction
// - synchronizer is latch open while clock high, then register
// - written pin value visible in input-sample one period later
// - single-bit set and clear change only the addressed pin
// - alternate function pins leave other pins as plain io
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/1ps

module gdp_port #(
  parameter int NP = gdp_pkg::GDP_PORTS
) (
  // apb slave
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic [gdp_pkg::GDP_AW-1:0]    paddr,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [31:0]                   pwdata,
  input  wire logic [3:0]                    pstrb,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  // pads
  input  wire logic [NP*gdp_pkg::GDP_PINS-1:0] pad_in,
  output logic      [NP*gdp_pkg::GDP_PINS-1:0] pad_out,
  output logic      [NP*gdp_pkg::GDP_PINS-1:0] pad_oe,
  output logic      [NP*gdp_pkg::GDP_PINS-1:0] pad_pullup,
  // alternate function overrides, same clock
  input  wire logic [NP*gdp_pkg::GDP_PINS-1:0] alt_en,
  input  wire logic [NP*gdp_pkg::GDP_PINS-1:0] alt_oe,
  input  wire logic [NP*gdp_pkg::GDP_PINS-1:0] alt_out
);
  import gdp_pkg::*;

  localparam int W = NP * GDP_PINS;

  // ==========================================================
  // address decode
  function automatic logic [11:0] ofs_in_port(input logic [11:0] a);
    ofs_in_port = a & (GDP_STRIDE - 12'h001);
  endfunction

  function automatic logic port_hit(input logic [11:0] a);
    logic [11:0] o;
    o = ofs_in_port(a);
    port_hit = (a[11:8] == 4'h0)
             && (int'(a[7:GDP_PORT_LSB]) < NP)
             && (o[1:0] == 2'b00)
             && (o <= GDP_OFS_DIR_CLR);
  endfunction

  logic [11:0] ofs;
  logic [2:0]  pidx;
  logic        hit_port;
  logic        hit_special;
  logic        hit_any;

  assign ofs         = ofs_in_port(paddr);
  assign pidx        = paddr[7:GDP_PORT_LSB];
  assign hit_port    = port_hit(paddr);
  assign hit_special = (paddr == GDP_OFS_SPECIAL);
  assign hit_any     = hit_port | hit_special;

  // ==========================================================
  // state
  // eight bits per port, bit n serves pin n
  logic [NP-1:0][7:0] out_q;
  logic [NP-1:0][7:0] out_d;
  logic [NP-1:0][7:0] dir_q;
  logic [NP-1:0][7:0] dir_d;
  logic [NP-1:0][7:0] smp_q;
  logic [NP-1:0][7:0] smp_d;
  logic               pud_q;
  logic               pud_d;
  logic               rdy_q;
  logic               rdy_d;
  logic               err_q;
  logic               err_d;
  logic [31:0]        rd_q;
  logic [31:0]        rd_d;

  // writes land only at the edge that completes the transfer
  logic wr_go;
  assign wr_go = psel & penable & rdy_q & pwrite & pstrb[0];

  // ==========================================================
  // register next values
  always_comb begin
    out_d = out_q;
    dir_d = dir_q;
    pud_d = pud_q;
    if (wr_go && hit_port && (int'(pidx) < NP)) begin
      unique case (ofs)
        GDP_OFS_OUT:     out_d[pidx] = pwdata[7:0];
        GDP_OFS_DIR:     dir_d[pidx] = pwdata[7:0];
        // other pins keep their bits
        GDP_OFS_OUT_SET: out_d[pidx] = out_q[pidx] | pwdata[7:0];
        GDP_OFS_OUT_CLR: out_d[pidx] = out_q[pidx] & ~pwdata[7:0];
        GDP_OFS_DIR_SET: dir_d[pidx] = dir_q[pidx] | pwdata[7:0];
        GDP_OFS_DIR_CLR: dir_d[pidx] = dir_q[pidx] & ~pwdata[7:0];
        default: ;
      endcase
    end else if (wr_go && hit_special) begin
      pud_d = pwdata[GDP_PUD_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int p = 0; p < NP; p++) begin
        out_q[p] <= GDP_OUT_RST;
        dir_q[p] <= GDP_DIR_RST;
      end
      pud_q <= GDP_PUD_RST;
    end else begin
      out_q <= out_d;
      dir_q <= dir_d;
      pud_q <= pud_d;
    end
  end

  // ==========================================================
  // apb answer: one wait cycle so read data comes from flops
  always_comb begin
    rdy_d = psel & penable & ~rdy_q;
    err_d = rdy_d & ~hit_any;
    rd_d  = rd_q;
    if (rdy_d) begin
      rd_d = 32'h0000_0000;
      if (hit_port && (int'(pidx) < NP)) begin
        unique case (ofs)
          GDP_OFS_OUT,
          GDP_OFS_OUT_SET,
          GDP_OFS_OUT_CLR: rd_d[7:0] = out_q[pidx];
          GDP_OFS_DIR,
          GDP_OFS_DIR_SET,
          GDP_OFS_DIR_CLR: rd_d[7:0] = dir_q[pidx];
          GDP_OFS_IN:      rd_d[7:0] = smp_q[pidx];
          default: ;
        endcase
      end else if (hit_special) begin
        rd_d[GDP_PUD_BIT] = pud_q;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_q <= 1'b0;
      err_q <= 1'b0;
      rd_q  <= 32'h0000_0000;
    end else begin
      rdy_q <= rdy_d;
      err_q <= err_d;
      rd_q  <= rd_d;
    end
  end

  assign pready  = rdy_q;
  assign pslverr = err_q;
  assign prdata  = rd_q;

  // ==========================================================
  // pad control
  // dir_q and out_q clear asynchronously, so pads float in reset
  // without any clock edge
  logic [W-1:0] dir_f;
  logic [W-1:0] out_f;

  always_comb begin
    for (int p = 0; p < NP; p++) begin
      dir_f[p*GDP_PINS +: GDP_PINS] = dir_q[p];
      out_f[p*GDP_PINS +: GDP_PINS] = out_q[p];
    end
  end

  // ==========================================================
  // pin configuration table
  typedef enum logic [1:0] {
    GDP_PIN_HIZ,
    GDP_PIN_PULLUP,
    GDP_PIN_LOW,
    GDP_PIN_HIGH
  } gdp_pin_mode_t;

  // direction wins over data; the global disable only gates the pull-up
  function automatic gdp_pin_mode_t pin_mode(input logic dir_b, input logic out_b, input logic pud_b);
    if (dir_b) begin
      pin_mode = out_b ? GDP_PIN_HIGH : GDP_PIN_LOW;
    end else if (out_b && !pud_b) begin
      pin_mode = GDP_PIN_PULLUP;
    end else begin
      pin_mode = GDP_PIN_HIZ;
    end
  endfunction

  gdp_pin_mode_t mode_f [W];

  always_comb begin
    for (int i = 0; i < W; i++) begin
      mode_f[i] = pin_mode(dir_f[i], out_f[i], pud_q);
    end
  end

  // presetn gates every enable, so reset floats pads with no clock
  always_comb begin
    for (int i = 0; i < W; i++) begin
      pad_out[i]    = out_f[i];
      pad_oe[i]     = 1'b0;
      pad_pullup[i] = 1'b0;
      if (alt_en[i]) begin
        // only pins claimed by an alternate function are overridden
        pad_oe[i]  = alt_oe[i] & presetn;
        pad_out[i] = alt_out[i];
      end else begin
        unique case (mode_f[i])
          GDP_PIN_HIGH,
          GDP_PIN_LOW:    pad_oe[i]     = presetn;
          GDP_PIN_PULLUP: pad_pullup[i] = presetn;
          GDP_PIN_HIZ:    pad_oe[i]     = 1'b0;
        endcase
      end
    end
  end

  // ==========================================================
  // input synchronizer
  // latch opens while pclk is high so a value driven at a rising
  // edge is sampled one full period later
  logic [W-1:0] sync_lat;

  always_latch begin
    if (pclk) begin
      sync_lat <= pad_in;
    end
  end

  always_comb begin
    for (int p = 0; p < NP; p++) begin
      smp_d[p] = sync_lat[p*GDP_PINS +: GDP_PINS];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int p = 0; p < NP; p++) begin
        smp_q[p] <= GDP_SMP_RST;
      end
    end else begin
      smp_q <= smp_d;
    end
  end

endmodule

// [gdp_tail_note.sv]
// no logic here: the port block lives in gdp_port.sv

// [gdp_port_sva.sv]
// checker for the port's apb timing and pad control
`timescale 1ns/1ps
module gdp_port_sva
  import gdp_pkg::*;
#(
  parameter int NP = 4
) (
  // apb
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic [GDP_AW-1:0] paddr,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic              pready,
  input wire logic              pslverr,
  // pads
  input wire logic [NP*8-1:0]   pad_out,
  input wire logic [NP*8-1:0]   pad_oe,
  input wire logic [NP*8-1:0]   pad_pullup,
  input wire logic [NP*8-1:0]   alt_en
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wr = psel && penable && pready && pwrite && pstrb[0];
  // port 0 pins only, while no alternate function owns them
  wire gp = alt_en[7:0] == 8'h00;
  // ==========================================================
  // assertions
  a_hiz_after_reset: assert property ($rose(presetn) |-> (pad_oe & ~alt_en) == '0)
    else $error("pin driven after reset");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_access_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("access phase not two cycles");
  a_err_unmapped: assert property (pready && paddr >= 12'h200 |-> pslverr)
    else $error("no error on unmapped address");
  a_dir_write: assert property (wr && gp && paddr == GDP_OFS_DIR |=> pad_oe[7:0] == $past(pwdata[7:0]))
    else $error("direction write not on pad_oe");
  a_out_write: assert property (wr && gp && paddr == GDP_OFS_OUT |=> pad_out[7:0] == $past(pwdata[7:0]))
    else $error("data write not on pad_out");
  a_set_only: assert property (wr && gp && paddr == GDP_OFS_OUT_SET |=>
    pad_out[7:0] == ($past(pad_out[7:0]) | $past(pwdata[7:0])))
    else $error("bit set touched other pins");
  a_pud_off: assert property (wr && paddr == GDP_OFS_SPECIAL && pwdata[GDP_PUD_BIT] |=> pad_pullup == '0)
    else $error("pull-up left on");
  c_dir_write: cover property (wr && paddr == GDP_OFS_DIR);
  c_refused: cover property (pslverr);
  c_pullup: cover property (pad_pullup != '0);
endmodule

bind gdp_port gdp_port_sva #(.NP(NP)) i_gdp_port_sva (.pclk(pclk), .presetn(presetn), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
  .pslverr(pslverr), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup), .alt_en(alt_en));

// [gdp_pad_env.sv]
// outside circuitry at the pads
`timescale 1ns/1ps
module gdp_pad_env #(
  parameter int N = 32
) (
  // clock
  input wire logic         pclk,
  // port side
  input wire logic [N-1:0] pad_out,
  input wire logic [N-1:0] pad_oe,
  input wire logic [N-1:0] pad_pullup,
  // bench control of outside drivers
  input wire logic [N-1:0] ext_val,
  input wire logic [N-1:0] ext_drv,
  output logic     [N-1:0] pad_in
);
  logic [N-1:0] flt_q = '0;
  // a floating pin must not look steady
  always @(posedge pclk) flt_q <= ~flt_q;
  always_comb pad_in = (pad_oe & pad_out) | (~pad_oe & ext_drv & ext_val) |
    (~pad_oe & ~ext_drv & (pad_pullup | flt_q));
endmodule

// [tb_gdp_port.sv]
// self-checking bench for the digital io port
`timescale 1ns/1ps
module tb_gdp_port;
  import gdp_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
  logic [11:0] paddr = '0, b;
  logic [31:0] pwdata = '0, prdata, rd, pad_in, pad_out, pad_oe, pad_pullup;
  logic [31:0] alt_en = '0, alt_oe = '0, alt_out = '0, ext_val = '0, ext_drv = '0;
  logic [3:0] pstrb = '0;
  logic [7:0] o, d, m, v;
  int seed = 65555, n_fail = 0, total_checks = 0, p;
  always #4 pclk = ~pclk;
  gdp_port #(.NP(4)) i_gdp_port (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup),
    .alt_en(alt_en), .alt_oe(alt_oe), .alt_out(alt_out));
  gdp_pad_env i_gdp_pad_env (.pclk(pclk), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup),
    .ext_val(ext_val), .ext_drv(ext_drv), .pad_in(pad_in));
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    total_checks++;
    if (got !== ex) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] dt, input logic [3:0] s);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    paddr <= a;
    pwrite <= w;
    pwdata <= dt;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(negedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      n_fail++;
      test_done;
    end
    rd = prdata;
    er = pslverr;
    @(posedge pclk);
    psel <= 0;
    penable <= 0;
  endtask
  function automatic logic [7:0] lvl(input logic [7:0] dr, ou, ed, ev);
    return (dr & ou) | (~dr & ed & ev) | (~dr & ~ed & ou);
  endfunction
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #200000;
    n_fail++;
    test_done;
  end
  initial begin
    repeat (12) @(posedge pclk);
    chk("oe", 0, pad_oe);
    presetn <= 1;
    alt_en <= 32'hff000000;
    alt_oe <= $random(seed);
    alt_out <= $random(seed);
    for (int i = 0; i < 24; i++) begin
      p = i % 3;
      b = 12'(GDP_STRIDE * p);
      o = $random(seed);
      d = $random(seed);
      ext_val <= $random(seed);
      ext_drv <= $random(seed);
      // data before direction keeps every switch on a legal path
      apb(b + GDP_OFS_OUT, 1, o, 1);
      apb(b + GDP_OFS_DIR, 1, d, 1);
      apb(b + GDP_OFS_IN, 0, 0, 1);
      m = d | o | ext_drv[p*8+:8];
      chk("sample", lvl(d, o, ext_drv[p*8+:8], ext_val[p*8+:8]) & m, rd[7:0] & m);
      chk("drive", {d, o}, {pad_oe[p*8+:8], pad_out[p*8+:8]});
      chk("pullup", 8'(~d & o), pad_pullup[p*8+:8]);
      apb(b + GDP_OFS_IN, 1, ~o, 1);
      apb(b + GDP_OFS_OUT, 0, 0, 1);
      chk("data reg", o, rd);
    end
    chk("alt", alt_oe[31:24], pad_oe[31:24]);
    apb(GDP_OFS_SPECIAL, 1, 1 << GDP_PUD_BIT, 1);
    apb(12'h200, 0, 0, 1);
    chk("unmapped", 1, er);
    chk("pullups", 0, pad_pullup);
    apb(GDP_OFS_SPECIAL, 1, 0, 1);
    for (int j = 0; j < 4; j++) begin
      b = j < 2 ? GDP_OFS_OUT : GDP_OFS_DIR;
      apb(b, 0, 0, 1);
      v = rd[7:0];
      m = 8'h01 << ($random(seed) & 7);
      apb(12'(GDP_OFS_OUT_SET + 4 * j), 1, m, 1);
      apb(b, 1, ~v, 4'he);
      apb(b, 0, 0, 1);
      chk("set clear", j % 2 ? v & ~m : v | m, rd);
    end
    presetn <= 0;
    @(posedge pclk);
    chk("reset pads", 0, pad_oe | pad_pullup);
    presetn <= 1;
    apb(GDP_OFS_DIR, 0, 0, 1);
    chk("dir reset", 0, rd);
    test_done;
  end
endmodule
